// ---- design/ubg_uart.sv ----
// uart with baud generator, modem lines and host register port
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

// Function
// - clock pin: oscillator or sixteen-times baud clock; the oscillator is shown halved
// - generator offers seventy-two selectable rates
// - cts level in status, change raises irq
// - cts false blocks start, line held mark
// - character in flight finishes despite cts
// - loop mode ignores cts
// - short characters: upper bits ignored, read zero
// - bit zero is lsb, sent first
// - data bus driven only during selected read
// - ready set on load, cleared by read
// - dsr level in status, change raises irq
// - dtr low when its bit is one
// - rts low when its bit is one
// - master enable gates irq, modem enable gates changes
// - strobes ignored without chip select
// - read returns register chosen by address
// - reset idles, clears modem control and receive flags; empty and done set
// - receiver ignores serial input in loop or reset
// - serial output mark when disabled, blocked or idle
// - mark is high, space is low
// - buffer empty set on transfer, cleared on write
// - loop mode routes transmit into receiver
// - echo mode retransmits input, buffer not sent
// - break mode holds the line at space, buffer not sent
module ubg_uart (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host register port
    input wire logic chip_select_n,
    input wire logic [1:0] reg_addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // serial line
    input wire logic serial_in,
    output logic serial_out,
    // modem lines
    input wire logic cts_n,
    input wire logic dsr_n,
    output logic dtr_n,
    output logic rts_n,
    // status and clock pins
    output logic irq_out,
    output logic rx_char_ready,
    output logic tx_buffer_empty,
    output logic clock_output_pin
);
    // configuration registers and bus decode
    logic [7:0] ctrl_reg, rate_select_reg, modem_control_reg;
    ubg_pkg::ubg_fmt_t fmt;
    logic wr_take, rd_take;
    // pin synchronisers: serial_in, cts_n, dsr_n
    logic [2:0] sync_a, sync_b;
    logic sin_s, cts_true, dsr_true;
    // baud generator
    logic [11:0] divisor, div_cnt;
    logic [1:0] pre_cnt;
    logic tick16, osc_half, baud_sq;
    // transmit and receive sides
    logic [7:0] tx_buffer_reg, rx_buffer_reg, rx_data;
    logic tx_done_flag, tx_start, tx_busy, tx_line;
    logic rx_line, rx_done, rx_perr, rx_ferr, rx_brk;
    logic overrun, parity_flag, frame_flag, break_flag;
    // modem status and decoded mode
    logic cts_prev, dsr_prev, delta_cts, delta_dsr;
    logic [1:0] mode;
    logic loop_mode, cts_ok, next_irq;
    logic [7:0] line_status, modem_status;

    // strobes count only with chip select low
    assign wr_take = wr_stb && !chip_select_n;
    assign rd_take = rd_stb && !chip_select_n;

    assign fmt = ubg_pkg::ubg_fmt_t'(ctrl_reg[4:0]);
    assign mode = modem_control_reg[ubg_pkg::MC_MODE_LO +: 2];
    assign loop_mode = (mode == ubg_pkg::MODE_LOOP);
    assign cts_ok = cts_true || loop_mode;

    // two flops on every serial and modem pin input before any logic looks at it
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
        end
        else
        begin
            sync_a <= {dsr_n, cts_n, serial_in};
            sync_b <= sync_a;
        end
    end

    assign sin_s = sync_b[0];
    assign cts_true = !sync_b[1];
    assign dsr_true = !sync_b[2];

    // control and rate registers; the data path gets its own process
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_reg <= ubg_pkg::CTRL_RESET;
            rate_select_reg <= ubg_pkg::RATE_RESET;
        end
        else if (wr_take)
        begin
            if (reg_addr == ubg_pkg::ADDR_CTRL)
                ctrl_reg <= data_in;
            if (reg_addr == ubg_pkg::ADDR_RATE)
                rate_select_reg <= data_in;
        end
    end

    // modem control and its pins; reset clears all, so the block idles
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            modem_control_reg <= ubg_pkg::MODEM_RESET;
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
        end
        else if (wr_take && reg_addr == ubg_pkg::ADDR_MODEM)
        begin
            modem_control_reg <= data_in;
            dtr_n <= !data_in[ubg_pkg::MC_DTR];
            rts_n <= !data_in[ubg_pkg::MC_RTS];
        end
    end

    // baud generator: divisor times prescale gives the 16x tick
    assign divisor = ubg_pkg::RATE_DIV[
        (rate_select_reg[4:0] > ubg_pkg::RATE_IDX_MAX) ?
        ubg_pkg::RATE_IDX_MAX : rate_select_reg[4:0]];

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            div_cnt <= 12'h000;
            pre_cnt <= 2'h0;
            tick16 <= 1'b0;
        end
        else if (div_cnt >= divisor - 12'h001)
        begin
            div_cnt <= 12'h000;
            if (pre_cnt >= rate_select_reg[ubg_pkg::RS_PRE_LO +: 2])
            begin
                pre_cnt <= 2'h0;
                tick16 <= 1'b1;
            end
            else
            begin
                pre_cnt <= pre_cnt + 2'h1;
                tick16 <= 1'b0;
            end
        end
        else
        begin
            div_cnt <= div_cnt + 12'h001;
            tick16 <= 1'b0;
        end
    end

    // clock pin; a flop cannot pass its own clock: osc shows halved
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            osc_half <= 1'b0;
            baud_sq <= 1'b0;
            clock_output_pin <= 1'b0;
        end
        else
        begin
            osc_half <= !osc_half;
            baud_sq <= (pre_cnt == 2'h0) && (div_cnt < (divisor >> 1));
            clock_output_pin <= rate_select_reg[ubg_pkg::RS_CLKOUT] ?
                                baud_sq : osc_half;
        end
    end

    // buffer hand-off: only when shifter is idle and cts allows
    assign tx_start = !tx_buffer_empty && !tx_busy && cts_ok
        && modem_control_reg[ubg_pkg::MC_TX_EN]
        && (mode == ubg_pkg::MODE_NORMAL || loop_mode);

    // transmit buffer and its flags; a write beats a same-cycle transfer
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_buffer_reg <= 8'h00;
            tx_buffer_empty <= 1'b1;
            tx_done_flag <= 1'b1;
        end
        else
        begin
            if (wr_take && reg_addr == ubg_pkg::ADDR_DATA)
            begin
                tx_buffer_reg <= data_in &
                    ubg_pkg::char_mask(fmt.char_len);
                tx_buffer_empty <= 1'b0;
            end
            else if (tx_start)
                tx_buffer_empty <= 1'b1;
            tx_done_flag <= tx_buffer_empty && !tx_busy && !tx_start;
        end
    end

    ubg_tx u_tx (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick16(tick16),
        .start(tx_start),
        .data(tx_buffer_reg),
        .fmt(fmt),
        .busy(tx_busy),
        .line(tx_line)
    );

    // loop mode feeds the shifter into the receiver, never the pin
    assign rx_line = loop_mode ? tx_line : sin_s;

    ubg_rx u_rx (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick16(tick16),
        .enable(modem_control_reg[ubg_pkg::MC_RX_EN]),
        .line(rx_line),
        .fmt(fmt),
        .done(rx_done),
        .data(rx_data),
        .parity_err(rx_perr),
        .frame_err(rx_ferr),
        .brk(rx_brk)
    );

    // receive buffer and status; a new event wins over a clearing read
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_buffer_reg <= 8'h00;
            rx_char_ready <= 1'b0;
            overrun <= 1'b0;
            parity_flag <= 1'b0;
            frame_flag <= 1'b0;
            break_flag <= 1'b0;
        end
        else
        begin
            if (rx_done)
                rx_buffer_reg <= rx_data;
            rx_char_ready <= rx_done || (rx_char_ready && !(rd_take
                && reg_addr == ubg_pkg::ADDR_DATA));
            if (rd_take && reg_addr == ubg_pkg::ADDR_CTRL)
            begin
                overrun <= rx_done && rx_char_ready;
                parity_flag <= rx_done && rx_perr;
                frame_flag <= rx_done && rx_ferr;
                break_flag <= rx_done && rx_brk;
            end
            else if (rx_done)
            begin
                overrun <= overrun || rx_char_ready;
                parity_flag <= parity_flag || rx_perr;
                frame_flag <= frame_flag || rx_ferr;
                break_flag <= break_flag || rx_brk;
            end
        end
    end

    // modem deltas; dsr feeds nothing but status and irq
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            cts_prev <= 1'b0;
            dsr_prev <= 1'b0;
            delta_cts <= 1'b0;
            delta_dsr <= 1'b0;
        end
        else
        begin
            cts_prev <= cts_true;
            dsr_prev <= dsr_true;
            if (cts_prev != cts_true)
                delta_cts <= 1'b1;
            else if (rd_take && reg_addr == ubg_pkg::ADDR_RATE)
                delta_cts <= 1'b0;
            if (dsr_prev != dsr_true)
                delta_dsr <= 1'b1;
            else if (rd_take && reg_addr == ubg_pkg::ADDR_RATE)
                delta_dsr <= 1'b0;
        end
    end

    // serial pin: mark unless a path is open; a character in flight
    // keeps the line after cts drops, so the far end never sees it cut
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            serial_out <= 1'b1;
        else if (!modem_control_reg[ubg_pkg::MC_TX_EN] || loop_mode
            || (!cts_true && !(mode == ubg_pkg::MODE_NORMAL && tx_busy)))
            serial_out <= 1'b1;
        else if (mode == ubg_pkg::MODE_ECHO)
            serial_out <= sin_s;
        else if (mode == ubg_pkg::MODE_BREAK)
            serial_out <= 1'b0;
        else
            serial_out <= tx_line;
    end

    // status words as read by the host
    assign line_status = {delta_cts || delta_dsr, tx_done_flag,
        tx_buffer_empty, break_flag, frame_flag, parity_flag, overrun,
        rx_char_ready};
    assign modem_status = {2'h0, dsr_true, cts_true, 2'h0, delta_dsr,
        delta_cts};

    // interrupt: master enable gates all; modem enable gates deltas
    assign next_irq = modem_control_reg[ubg_pkg::MC_IRQ_EN] &&
        (rx_char_ready || tx_buffer_empty || overrun || parity_flag
         || frame_flag || break_flag
         || (modem_control_reg[ubg_pkg::MC_MODEM_IRQ]
             && (delta_cts || delta_dsr)));

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            irq_out <= 1'b0;
        else
            irq_out <= next_irq;
    end

    // read data stands for one cycle; bus released otherwise
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end
        else
        begin
            data_oe_n <= !rd_take;
            if (rd_take)
            begin
                case (reg_addr)
                    ubg_pkg::ADDR_DATA: data_out <= rx_buffer_reg;
                    ubg_pkg::ADDR_CTRL: data_out <= line_status;
                    ubg_pkg::ADDR_RATE: data_out <= modem_status;
                    default: data_out <= modem_control_reg;
                endcase
            end
            else
                data_out <= 8'h00;
        end
    end
endmodule : ubg_uart

// ---- include/ubg_pkg.sv ----
// shared constants, format struct and decode helpers for the uart block
package ubg_pkg;

    // register select codes on the two address lines
    localparam logic [1:0] ADDR_DATA = 2'h0;
    localparam logic [1:0] ADDR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_RATE = 2'h2;
    localparam logic [1:0] ADDR_MODEM = 2'h3;

    // modem control register fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_IRQ_EN = 2;
    localparam int MC_MODEM_IRQ = 3;
    localparam int MC_RX_EN = 4;
    localparam int MC_TX_EN = 5;
    localparam int MC_MODE_LO = 6;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ECHO = 2'h1;
    localparam logic [1:0] MODE_LOOP = 2'h2;
    localparam logic [1:0] MODE_BREAK = 2'h3;

    // rate select register fields: 18 rates times 4 prescales
    localparam int RS_CLKOUT = 7;
    localparam int RS_PRE_LO = 5;
    localparam logic [4:0] RATE_IDX_MAX = 5'h11;
    // 16x divisors of the eighteen rates, index 0 in the low word
    localparam logic [17:0][11:0] RATE_DIV = {
        12'h002, 12'h003, 12'h006, 12'h00C, 12'h010, 12'h018,
        12'h020, 12'h030, 12'h03A, 12'h040, 12'h060, 12'h0C0,
        12'h180, 12'h300, 12'h359, 12'h417, 12'h600, 12'h900};

    // line status and modem status bits
    localparam int LS_READY = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAME = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_TBE = 5;
    localparam int LS_DONE = 6;
    localparam int LS_MODEM = 7;
    localparam int MS_DCTS = 0;
    localparam int MS_DDSR = 1;
    localparam int MS_CTS = 4;
    localparam int MS_DSR = 5;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h03;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] MODEM_RESET = 8'h00;

    // sixteen ticks per bit, start verified on tick seven
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;

    // character format, laid out as control register bits 4..0
    typedef struct packed {
        logic parity_even;
        logic parity_en;
        logic two_stop;
        logic [1:0] char_len;
    } ubg_fmt_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ubg_rx_state_t;

    // mask of the data bits in use for a character length code
    function automatic logic [7:0] char_mask(input logic [1:0] len);
        case (len)
            2'h0: char_mask = 8'h1F;
            2'h1: char_mask = 8'h3F;
            2'h2: char_mask = 8'h7F;
            default: char_mask = 8'hFF;
        endcase
    endfunction : char_mask

endpackage : ubg_pkg

// ---- design/ubg_tx.sv ----
// transmit shift register: frames one character, lsb first
`timescale 1ns/1ps
module ubg_tx (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic tick16,
    input wire logic start,
    input wire logic [7:0] data,
    input wire ubg_pkg::ubg_fmt_t fmt,
    // status and line
    output logic busy,
    output logic line
);
    logic [11:0] shreg;
    logic [11:0] next_frame;
    logic [3:0] bits_left;
    logic [3:0] next_count;
    logic [3:0] tick_cnt;
    logic [3:0] dlen;
    logic par;

    // build the whole frame: start, data lsb first, parity, stops
    always_comb
    begin
        dlen = 4'h5 + {2'h0, fmt.char_len};
        par = fmt.parity_even ? ^data : ~^data;
        next_frame = 12'hFFF;
        next_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < int'(dlen))
                next_frame[i + 1] = data[i];
        end
        if (fmt.parity_en)
            next_frame[dlen + 4'h1] = par;
        next_count = dlen + 4'h2 + {3'h0, fmt.parity_en}
                     + {3'h0, fmt.two_stop};
    end

    // shift one bit out per sixteen ticks
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            shreg <= 12'hFFF;
            bits_left <= 4'h0;
            tick_cnt <= 4'h0;
            busy <= 1'b0;
        end
        else if (start)
        begin
            shreg <= next_frame;
            bits_left <= next_count;
            tick_cnt <= 4'h0;
            busy <= 1'b1;
        end
        else if (busy && tick16)
        begin
            tick_cnt <= tick_cnt + 4'h1;
            if (tick_cnt == ubg_pkg::TICK_LAST)
            begin
                shreg <= {1'b1, shreg[11:1]};
                bits_left <= bits_left - 4'h1;
                if (bits_left == 4'h1)
                    busy <= 1'b0;
            end
        end
    end

    assign line = busy ? shreg[0] : 1'b1;
endmodule : ubg_tx

// ---- design/ubg_rx.sv ----
// receive shift logic: start verify, centre sampling, error checks
`timescale 1ns/1ps
module ubg_rx (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic tick16,
    input wire logic enable,
    input wire logic line,
    input wire ubg_pkg::ubg_fmt_t fmt,
    // result
    output logic done,
    output logic [7:0] data,
    output logic parity_err,
    output logic frame_err,
    output logic brk
);
    ubg_pkg::ubg_rx_state_t state;
    logic prev;
    logic [3:0] tick_cnt;
    logic [3:0] bit_idx;
    logic [9:0] bits;
    logic [3:0] dlen;
    logic [3:0] nbits;
    logic par_bit;
    logic stop_bit;

    assign dlen = 4'h5 + {2'h0, fmt.char_len};
    assign nbits = dlen + 4'h1 + {3'h0, fmt.parity_en};

    // sample on ticks; a low glitch that is gone by mid start is dropped
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= ubg_pkg::RX_IDLE;
            prev <= 1'b1;
            tick_cnt <= 4'h0;
            bit_idx <= 4'h0;
            bits <= 10'h000;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!enable)
                state <= ubg_pkg::RX_IDLE;
            else if (tick16)
            begin
                prev <= line;
                tick_cnt <= tick_cnt + 4'h1;
                case (state)
                    ubg_pkg::RX_IDLE:
                        if (prev && !line)
                        begin
                            state <= ubg_pkg::RX_START;
                            tick_cnt <= 4'h0;
                        end
                    ubg_pkg::RX_START:
                        if (tick_cnt == ubg_pkg::TICK_MID)
                        begin
                            tick_cnt <= 4'h0;
                            bit_idx <= 4'h0;
                            state <= line ? ubg_pkg::RX_IDLE
                                          : ubg_pkg::RX_BITS;
                        end
                    ubg_pkg::RX_BITS:
                        if (tick_cnt == ubg_pkg::TICK_LAST)
                        begin
                            bits[bit_idx] <= line;
                            bit_idx <= bit_idx + 4'h1;
                            if (bit_idx == nbits - 4'h1)
                            begin
                                done <= 1'b1;
                                state <= ubg_pkg::RX_IDLE;
                            end
                        end
                    default: state <= ubg_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // unused upper data bits read as zero
    assign data = bits[7:0] & ubg_pkg::char_mask(fmt.char_len);
    assign par_bit = bits[dlen];
    assign stop_bit = bits[nbits - 4'h1];
    assign parity_err = fmt.parity_en &&
        (par_bit != (fmt.parity_even ? ^data : ~^data));
    assign frame_err = !stop_bit;
    assign brk = (data == 8'h00) && !stop_bit &&
        !(fmt.parity_en && par_bit);
endmodule : ubg_rx

// ---- tb/ubg_uart_chk.sv ----
// assertion checker for the uart host port and modem pins
`timescale 1ns/1ps
module ubg_uart_chk (
    // clock, reset and host port
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic [1:0] reg_addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] data_in,
    input wire logic data_oe_n,
    // line and status pins
    input wire logic serial_out,
    input wire logic cts_n,
    input wire logic dtr_n,
    input wire logic rts_n,
    input wire logic irq_out,
    input wire logic rx_char_ready,
    input wire logic tx_buffer_empty
);
    logic wr_ok, rd_ok, mc_wr, dat_wr, dat_rd, irq_en, loop_on;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // decoded host accesses
    assign wr_ok = wr_stb && !chip_select_n;
    assign rd_ok = rd_stb && !chip_select_n;
    assign mc_wr = wr_ok && reg_addr == ubg_pkg::ADDR_MODEM;
    assign dat_wr = wr_ok && reg_addr == ubg_pkg::ADDR_DATA;
    assign dat_rd = rd_ok && reg_addr == ubg_pkg::ADDR_DATA;
    // shadows of irq enable and loop mode, taken from host writes
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            irq_en <= 1'b0;
            loop_on <= 1'b0;
        end
        else if (mc_wr)
        begin
            irq_en <= data_in[ubg_pkg::MC_IRQ_EN];
            loop_on <= data_in[ubg_pkg::MC_MODE_LO +: 2] == ubg_pkg::MODE_LOOP;
        end
    end
    property p_bus_idle; !data_oe_n |-> $past(rd_ok); endproperty
    a_bus_idle: assert property (p_bus_idle)
        else $error("bus driven without read");
    property p_read_ans; rd_ok |=> !data_oe_n; endproperty
    a_read_ans: assert property (p_read_ans)
        else $error("read not answered");
    property p_dtr_set; $fell(dtr_n) |-> $past(mc_wr && data_in[0]); endproperty
    a_dtr_set: assert property (p_dtr_set)
        else $error("dtr fell without write");
    property p_rts_clr; $rose(rts_n) |-> $past(mc_wr && !data_in[1]); endproperty
    a_rts_clr: assert property (p_rts_clr)
        else $error("rts rose without write");
    property p_rdy_clr; $fell(rx_char_ready) |-> $past(dat_rd); endproperty
    a_rdy_clr: assert property (p_rdy_clr)
        else $error("ready fell without read");
    property p_tbe_clr; $fell(tx_buffer_empty) |-> $past(dat_wr); endproperty
    a_tbe_clr: assert property (p_tbe_clr)
        else $error("empty fell without write");
    property p_irq_gate; irq_out |-> irq_en || $past(irq_en); endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq while disabled");
    // six cycles cover the sync flops; no hand-off while cts is false
    property p_cts_mark;
        (cts_n && !loop_on) [*6] |-> !$rose(tx_buffer_empty);
    endproperty
    a_cts_mark: assert property (p_cts_mark)
        else $error("character started while cts false");
    c_read: cover property (rd_ok ##1 !data_oe_n);
    c_dtr: cover property ($fell(dtr_n));
    c_rdy: cover property ($rose(rx_char_ready));
endmodule : ubg_uart_chk
bind ubg_uart ubg_uart_chk i_ubg_uart_chk (.*);

// ---- tb/ubg_modem_model.sv ----
// far-end modem: loops the line back, promptly or late, drives modem pins
`timescale 1ns/1ps
module ubg_modem_model (
    // bench controls
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic cts_off,
    input wire logic dsr_off,
    // line side
    input wire logic serial_out,
    output logic serial_in,
    output logic cts_n,
    output logic dsr_n
);
    logic [3:0] dly = 4'hF;
    // late path lags four cycles, far below one bit time
    always_ff @(posedge sys_clk)
        dly <= {dly[2:0], serial_out};
    assign serial_in = slow ? dly[3] : serial_out;
    assign cts_n = cts_off;
    assign dsr_n = dsr_off;
endmodule : ubg_modem_model

// ---- tb/tb_ubg_uart.sv ----
// self-checking bench for the uart block
`timescale 1ns/1ps
module tb_ubg_uart;
    logic sys_clk, reset, chip_select_n, wr_stb, rd_stb, slow;
    logic cts_off, dsr_off, data_oe_n, serial_in, serial_out, cts_n;
    logic dsr_n, dtr_n, rts_n, irq_out, rx_char_ready, tx_buffer_empty;
    logic clock_output_pin;
    logic [1:0] reg_addr;
    logic [7:0] data_in, data_out, v, d;
    logic [31:0] seed = 32'hCF67C7FE;
    int mismatches = 0;
    int cmp_count = 0;
    int q[$];
    ubg_uart i_ubg_uart (.*);
    ubg_modem_model i_ubg_modem_model (.*);
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic wr(input logic [1:0] a, input logic [7:0] x, input logic c);
        @(posedge sys_clk);
        chip_select_n <= c;
        reg_addr <= a;
        data_in <= x;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        chip_select_n <= 1'b1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        reg_addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        chip_select_n <= 1'b1;
        @(negedge sys_clk);
        v = data_out;
    endtask : rd
    task automatic wt(input logic tbe);
        for (int n = 0; n < 2000; n++)
        begin
            @(negedge sys_clk);
            if ((tbe ? tx_buffer_empty : rx_char_ready) === 1'b1)
                return;
        end
        $display("mismatch at %0t: timeout", $time);
        mismatches++;
        close_out();
    endtask : wt
    // model keeps only the bits of the chosen length
    task automatic tx(input int len);
        d = rnd();
        wr(ubg_pkg::ADDR_DATA, d, 1'b0);
        q.push_back(int'(d) % (32 << len));
    endtask : tx
    task automatic rx_cmp();
        wt(1'b0);
        rd(ubg_pkg::ADDR_DATA);
        chk(v, 8'(q.pop_front()));
        chk({7'h0, rx_char_ready}, 8'h00);
    endtask : rx_cmp
    initial
    begin
        reset = 1'b1;
        chip_select_n = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        reg_addr = 2'h0;
        data_in = 8'h00;
        slow = 1'b0;
        cts_off = 1'b1;
        dsr_off = 1'b1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ubg_pkg::ADDR_CTRL);
        chk(v, 8'h60);
        chk({4'h0, dtr_n, rts_n, tx_buffer_empty, irq_out}, 8'h0E);
        wr(ubg_pkg::ADDR_MODEM, 8'h03, 1'b1);
        rd(ubg_pkg::ADDR_MODEM);
        chk(v, 8'h00);
        wr(ubg_pkg::ADDR_MODEM, 8'h03, 1'b0);
        rd(ubg_pkg::ADDR_MODEM);
        chk(v, 8'h03);
        chk({6'h0, dtr_n, rts_n}, 8'h00);
        wr(ubg_pkg::ADDR_MODEM, 8'h00, 1'b0);
        rd(ubg_pkg::ADDR_MODEM);
        chk({6'h0, dtr_n, rts_n}, 8'h03);
        $display("test reset and modem pins done");
        // loop mode with cts false, every character length
        wr(ubg_pkg::ADDR_RATE, 8'h11, 1'b0);
        for (int l = 0; l < 4; l++)
        begin
            wr(ubg_pkg::ADDR_CTRL, 8'(l), 1'b0);
            wr(ubg_pkg::ADDR_MODEM, 8'hB0, 1'b0);
            tx(l);
            rx_cmp();
            chk({7'h0, serial_out}, 8'h01);
        end
        $display("test loop mode done");
        // normal mode through the far end, held until cts turns true
        d = rnd();
        slow <= d[0];
        wr(ubg_pkg::ADDR_MODEM, 8'h30, 1'b0);
        tx(3);
        repeat (700) @(posedge sys_clk);
        chk({7'h0, rx_char_ready}, 8'h00);
        cts_off <= 1'b0;
        rx_cmp();
        tx(3);
        wt(1'b1);
        tx(3);
        rx_cmp();
        rx_cmp();
        $display("test normal mode done");
        rd(ubg_pkg::ADDR_RATE);
        chk(v & 8'h01, 8'h01);
        dsr_off <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(ubg_pkg::ADDR_RATE);
        chk(v & 8'h03, 8'h02);
        wr(ubg_pkg::ADDR_MODEM, 8'h38, 1'b0);
        rd(ubg_pkg::ADDR_MODEM);
        chk({7'h0, irq_out}, 8'h00);
        wr(ubg_pkg::ADDR_MODEM, 8'h3C, 1'b0);
        rd(ubg_pkg::ADDR_MODEM);
        chk({7'h0, irq_out}, 8'h01);
        wr(ubg_pkg::ADDR_MODEM, 8'hE0, 1'b0);
        rd(ubg_pkg::ADDR_MODEM);
        chk({7'h0, serial_out}, 8'h00);
        $display("test status, irq and break done");
        close_out();
    end
endmodule : tb_ubg_uart
